// [hdl/aeir_top.v]
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "aeir_regs.vh"

module aeir_top (
   input wire clk_i,
   input wire rst_i,
   // classic wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // one-cycle event pulses from converter logic on the same clock
   input wire started_evt_i,
   input wire buf_filled_evt_i,
   input wire task_done_evt_i,
   input wire result_ready_evt_i,
   input wire cal_complete_evt_i,
   input wire conv_halted_evt_i,
   // latest result with its channel, checked against that channel's limits
   input wire result_valid_i,
   input wire [2:0] result_ch_i,
   input wire [`AEIR_RESULT_W-1:0] result_i,
   input wire [`AEIR_NUM_CH*`AEIR_RESULT_W-1:0] high_limit_i,
   input wire [`AEIR_NUM_CH*`AEIR_RESULT_W-1:0] low_limit_i,
   output wire irq_o
);

   localparam NE = `AEIR_NUM_EVENTS;
   localparam RW = `AEIR_RESULT_W;
   // index value that marks "not an event word", sized for the 5-bit index
   localparam [4:0] NO_EVT = 5'h16;

   reg [NE-1:0] flag;
   reg [NE-1:0] mask;
   reg [NE-1:0] next_flag;
   reg [NE-1:0] next_mask;
   reg [31:0] next_rdata;
   wire [NE-1:0] evt_set;
   wire [`AEIR_NUM_CH-1:0] upper_hit;
   wire [`AEIR_NUM_CH-1:0] lower_hit;
   wire [`AEIR_ADR_W-1:0] adr;
   wire req;
   wire wr_now;
   wire [31:0] lane_mask;
   integer i;

   // returns the event index of an event word, or NE when not an event word
   function [4:0] evt_index;
      input [`AEIR_ADR_W-1:0] a;
      reg [`AEIR_ADR_W-1:0] d;
      begin
         d = a - `AEIR_EVT_BASE;
         if (a >= `AEIR_EVT_BASE && d[11:2] < NE && d[1:0] == 2'h0) begin
            evt_index = d[6:2];
         end else begin
            evt_index = NO_EVT;
         end
      end
   endfunction

   function [31:0] sel_to_mask;
      input [3:0] s;
      begin
         sel_to_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      end
   endfunction

   assign adr = wb_adr_i[`AEIR_ADR_W-1:0];
   assign req = wb_cyc_i & wb_stb_i;
   // writes land on the edge where the master samples ack, never earlier
   assign wr_now = req & wb_we_i & wb_ack_o;
   assign lane_mask = sel_to_mask(wb_sel_i);

   // signed compare: results below zero are legal in differential mode
   genvar g;
   generate
      for (g = 0; g < `AEIR_NUM_CH; g = g + 1) begin : g_limit
         assign upper_hit[g] = result_valid_i && (result_ch_i == g) &&
            ($signed(result_i) >= $signed(high_limit_i[g*RW +: RW]));
         assign lower_hit[g] = result_valid_i && (result_ch_i == g) &&
            ($signed(result_i) <= $signed(low_limit_i[g*RW +: RW]));
         assign evt_set[`AEIR_BIT_CH_UPPER0 + 2*g] = upper_hit[g];
         assign evt_set[`AEIR_BIT_CH_LOWER0 + 2*g] = lower_hit[g];
      end
   endgenerate

   assign evt_set[`AEIR_BIT_STARTED] = started_evt_i;
   assign evt_set[`AEIR_BIT_BUF_FILLED] = buf_filled_evt_i;
   assign evt_set[`AEIR_BIT_TASK_DONE] = task_done_evt_i;
   assign evt_set[`AEIR_BIT_RESULT_READY] = result_ready_evt_i;
   assign evt_set[`AEIR_BIT_CAL_COMPLETE] = cal_complete_evt_i;
   assign evt_set[`AEIR_BIT_CONV_HALTED] = conv_halted_evt_i;

   // flag update: software write first, hardware set last so it wins
   always @* begin
      next_flag = flag;
      if (wr_now) begin
         if (evt_index(adr) != NO_EVT && wb_sel_i[0]) begin
            next_flag[evt_index(adr)] = wb_dat_i[0];
         end
         if (adr == `AEIR_OFS_INT_STATUS) begin
            next_flag = flag & ~(wb_dat_i[NE-1:0] & lane_mask[NE-1:0]);
         end
      end
      for (i = 0; i < NE; i = i + 1) begin
         if (evt_set[i]) begin
            next_flag[i] = 1'b1;
         end
      end
   end

   always @* begin
      next_mask = mask;
      if (wr_now && adr == `AEIR_OFS_INT_MASK) begin
         next_mask = (mask & ~lane_mask[NE-1:0]) |
            (wb_dat_i[NE-1:0] & lane_mask[NE-1:0]);
      end
   end

   // reserved bits of every word read as zero; unmapped words read zero
   always @* begin
      next_rdata = 32'h00000000;
      if (evt_index(adr) != NO_EVT) begin
         next_rdata[0] = flag[evt_index(adr)];
      end else if (adr == `AEIR_OFS_INT_MASK) begin
         next_rdata[NE-1:0] = mask;
      end else if (adr == `AEIR_OFS_INT_STATUS) begin
         next_rdata[NE-1:0] = flag;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         flag <= `AEIR_RST_FLAGS;
         mask <= `AEIR_RST_MASK;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         flag <= next_flag;
         mask <= next_mask;
         // one wait state; ack drops the cycle after it is given
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o & ~wb_we_i) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

   // every mask bit gates the flag at the same position:
   // bit 0..3 started/filled/done/ready, 4 calibration, 5 halted, 6+ limits
   assign irq_o = |(flag & mask);

endmodule

`default_nettype wire

// [shared/aeir_regs.vh]
`ifndef AEIR_REGS_VH
`define AEIR_REGS_VH

// event flag registers, one word each, contiguous from this base
`define AEIR_EVT_BASE 12'h100
`define AEIR_OFS_STARTED 12'h100
`define AEIR_OFS_BUF_FILLED 12'h104
`define AEIR_OFS_TASK_DONE 12'h108
`define AEIR_OFS_RESULT_READY 12'h10c
`define AEIR_OFS_CAL_COMPLETE 12'h110
`define AEIR_OFS_CONV_HALTED 12'h114
`define AEIR_OFS_CH_UPPER 12'h118
`define AEIR_OFS_CH_LOWER 12'h11c
`define AEIR_CH_STRIDE 12'h008
`define AEIR_OFS_INT_MASK 12'h300
`define AEIR_OFS_INT_STATUS 12'h400

// event bit positions, shared by flags, mask and status
`define AEIR_BIT_STARTED 0
`define AEIR_BIT_BUF_FILLED 1
`define AEIR_BIT_TASK_DONE 2
`define AEIR_BIT_RESULT_READY 3
`define AEIR_BIT_CAL_COMPLETE 4
`define AEIR_BIT_CONV_HALTED 5
`define AEIR_BIT_CH_UPPER0 6
`define AEIR_BIT_CH_LOWER0 7

`define AEIR_NUM_EVENTS 22
`define AEIR_NUM_CH 8
`define AEIR_RESULT_W 16
`define AEIR_ADR_W 12

`define AEIR_RST_FLAGS 22'h000000
`define AEIR_RST_MASK 22'h000000

`endif

// [testbench/aeir_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module aeir_checker (
   input wire clk_i, input wire rst_i, input wire wb_cyc_i, input wire wb_stb_i,
   input wire wb_we_i, input wire [31:0] wb_adr_i, input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i, input wire [31:0] wb_dat_o, input wire wb_ack_o,
   input wire cal_complete_evt_i, input wire irq_o
);
   logic [21:0] m;
   wire [21:0] bm = {{6{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire rd = wb_ack_o && !wb_we_i;
   // mask mirror, written on the edge where the master sees ack
   always @(posedge clk_i) begin
      if (rst_i)
         m <= 22'h0;
      else if (wb_ack_o && wb_we_i && wb_adr_i[11:0] == 12'h300)
         m <= (m & ~bm) | (wb_dat_i[21:0] & bm);
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   property p_ack; s_req |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_one: assert property (p_one) else $error("ack too long");
   property p_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_src: assert property (p_src) else $error("ack unasked");
   property p_mrd; rd && wb_adr_i[11:0] == 12'h300 |-> wb_dat_o == {10'h0, m}; endproperty
   a_mrd: assert property (p_mrd) else $error("mask read");
   property p_frd; rd && wb_adr_i[11:7] == 5'h02 |-> wb_dat_o[31:1] == 31'h0; endproperty
   a_frd: assert property (p_frd) else $error("flag width");
   property p_unm; rd && wb_adr_i[11:0] == 12'h200 |-> wb_dat_o == 32'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read");
   property p_irq; m == 22'h0 |-> !irq_o; endproperty
   a_irq: assert property (p_irq) else $error("irq unmasked");
   property p_cal; cal_complete_evt_i && m[4] |=> irq_o || !m[4]; endproperty
   a_cal: assert property (p_cal) else $error("cal irq");
endmodule
bind aeir_top aeir_checker u_chk (.*);
`default_nettype wire

// [testbench/tb_aeir_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_aeir_top;
   logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, rv = 1'h0;
   logic [31:0] adr = 32'h0, dat = 32'h0, q;
   logic [11:0] ra [6] = '{12'h110, 12'h114, 12'h118, 12'h11c, 12'h300, 12'h200};
   logic [5:0] ev = 6'h0;
   logic [3:0] sel = 4'hf;
   logic [2:0] ch = 3'h0;
   logic [15:0] res = 16'h0;
   wire [31:0] dout;
   wire ack, irq;
   integer fail_count = 0, checked = 0, i;
   always #2.5 clk_i = ~clk_i;
   aeir_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
      .wb_ack_o(ack), .started_evt_i(ev[0]), .buf_filled_evt_i(ev[1]),
      .task_done_evt_i(ev[2]), .result_ready_evt_i(ev[3]), .cal_complete_evt_i(ev[4]),
      .conv_halted_evt_i(ev[5]), .result_valid_i(rv), .result_ch_i(ch), .result_i(res),
      .high_limit_i({8{16'h0064}}), .low_limit_i({8{16'hff9c}}), .irq_o(irq));
   task cmp(input [31:0] g, input [31:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask
   task end_of_test;
      $display("checked %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // request held until the edge where ack is sampled high
   task acc(input [31:0] a, input w, input [31:0] d);
      integer k;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
      for (k = 0; k < 9 && ack !== 1'h1; k++) @(posedge clk_i);
      q = dout;
      {cyc, stb} <= 2'h0;
      if (k == 9) begin
         fail_count++;
         end_of_test;
      end
   endtask
   task ci(input e);
      @(posedge clk_i);
      cmp(irq, e);
   endtask
   task rs(input [15:0] v);
      @(posedge clk_i);
      {rv, res} <= {1'h1, v};
      @(posedge clk_i);
      rv <= 1'h0;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      for (i = 0; i < 6; i++) begin
         acc(ra[i], 1'h0, 32'h0);
         cmp(q, 32'h0);
      end
      sel <= 4'h1;
      acc(32'h300, 1'h1, 32'hffffffff);
      sel <= 4'hf;
      acc(32'h300, 1'h0, 32'h0);
      cmp(q, 32'hff);
      acc(32'h300, 1'h1, 32'hffffffff);
      acc(32'h300, 1'h0, 32'h0);
      cmp(q, 32'h3fffff);
      acc(32'h300, 1'h1, 32'h0);
      $display("reset and mask test done");
      for (i = 0; i < 6; i++) begin
         @(posedge clk_i);
         ev <= 6'h1 << i;
         @(posedge clk_i);
         ev <= 6'h0;
         acc(32'h100 + 4 * i, 1'h0, 32'h0);
         cmp(q, 32'h1);
         ci(1'h0);
         acc(32'h300, 1'h1, 32'h1 << i);
         ci(1'h1);
         acc(32'h100 + 4 * i, 1'h1, 32'h0);
         ci(1'h0);
         acc(32'h300, 1'h1, 32'h0);
      end
      $display("event test done");
      for (i = 0; i < 8; i++) begin
         ch <= i[2:0];
         rs(16'h0063);
         acc(32'h118 + 8 * i, 1'h0, 32'h0);
         cmp(q, 32'h0);
         rs(16'h0064);
         acc(32'h118 + 8 * i, 1'h0, 32'h0);
         cmp(q, 32'h1);
         rs(16'hff9c);
         acc(32'h11c + 8 * i, 1'h0, 32'h0);
         cmp(q, 32'h1);
         acc(32'h300, 1'h1, 32'h3 << (6 + 2 * i));
         ci(1'h1);
         acc(32'h118 + 8 * i, 1'h1, 32'h0);
         acc(32'h11c + 8 * i, 1'h1, 32'h0);
         ci(1'h0);
         acc(32'h300, 1'h1, 32'h0);
      end
      $display("limit test done");
      @(posedge clk_i);
      ev <= 6'h30;
      @(posedge clk_i);
      ev <= 6'h20;
      acc(32'h400, 1'h0, 32'h0);
      cmp(q, 32'h30);
      acc(32'h114, 1'h1, 32'h0);
      ev <= 6'h0;
      acc(32'h114, 1'h0, 32'h0);
      cmp(q, 32'h1);
      acc(32'h400, 1'h1, 32'h30);
      acc(32'h400, 1'h0, 32'h0);
      cmp(q, 32'h0);
      $display("status test done");
      end_of_test;
   end
endmodule
`default_nettype wire
